/* File: hw/psc_pkg.sv */
// package of constants for the power-saving clock control block
package psc_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CLOCK_DIVIDER_REGISTER = 8'h00;
   localparam logic [7:0] ADDR_RSTCTL = 8'h04;
   localparam logic [7:0] ADDR_MODCTL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_OSCSEL = 8'h10;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CPU_SLOWDOWN_ENABLE_BIT = 11;
   localparam int RATIO_LSB = 12;
   localparam int ROI_BIT = 15;
   localparam int REGULATOR_STANDBY_SELECT_BIT = 8;
   localparam int MDIS_LSB = 0;
   localparam int MEN_LSB = 8;
   localparam int MIDL_LSB = 16;
   localparam int LOCK_BIT = 4;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] RATIO_RST = 3'h0;
   localparam logic [2:0] OSC_RST = 3'h0;
   localparam logic [7:0] MEN_RST = 8'hff;
   // ---------------------------------------------------------------
   // power-save operands and timing
   // ---------------------------------------------------------------
   localparam logic OPER_SLEEP = 1'b0;
   localparam logic OPER_IDLE = 1'b1;
   localparam int CLK_MHZ = 20;
   localparam int VREG_WAKE_US = 10;
   localparam int VREG_WAKE_CYC = VREG_WAKE_US * CLK_MHZ;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_IDLE, PS_WAKE} psc_state_t;
endpackage

/* File: hw/psc_top.sv */
// power-saving clock control: sleep/idle, doze and module gating
// Contract
// - power-save instruction operand 0 enters sleep, operand 1 enters idle.
// - sleep stops system clock and oscillator; idle halts only the cpu.
// - enabled interrupt, any reset or watchdog time-out wakes the device.
// - watchdog counter is cleared before sleep when watchdog enabled.
// - low-power rc clock keeps running in sleep if watchdog enabled.
// - fail-safe clock monitor is suspended during sleep.
// - system-clock peripherals stop in sleep; external-clock ones may run.
// - regulator standby in sleep when select bit clear; adds wake delay.
// - after sleep the cpu resumes on the clock source used before.
// - watchdog counter is cleared on idle entry.
// - in idle rc clock stays on if watchdog or clock monitor enabled.
// - on idle wake the cpu clock returns and execution resumes at once.
// - interrupt during the instruction waits until entry completes, then wakes.
// - slowdown enable reduces cpu rate; system and peripheral clocks unchanged.
// - 3-bit ratio picks 1:1 to 1:128; default 1:1.
// - cpu and peripheral domains stay in step while slowed.
// - return-on-interrupt set: interrupt restores full speed; clear: no effect.
// - module disable gates all module clocks; register access blocked.
// - clearing module enable stops function; registers stay accessible.
// - stop-in-idle bit disables the module on idle; default keeps running.
// - writing oscillator select while unlocked starts a clock switch.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
module psc_top
   import psc_pkg::*;
#(
   parameter int NMOD = 8,
   parameter int VREG_CYC = VREG_WAKE_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pwrsave_exec,
   input wire logic pwrsave_operand,
   input wire logic irq_pending,
   input wire logic wdt_timeout,
   input wire logic wdt_enable,
   input wire logic fail_safe_clock_monitor_enable,
   input wire logic clock_switch_done,
   output logic cpu_clk_en,
   output logic sys_clk_en,
   output logic periph_clk_en,
   output logic osc_enable,
   output logic low_power_rc_clock_enable,
   output logic fail_safe_clock_monitor_active,
   output logic wdt_clear,
   output logic vreg_standby,
   output logic cpu_resume,
   output logic [2:0] active_osc,
   output logic clock_switch_start,
   output logic [NMOD-1:0] module_clk_en,
   output logic [NMOD-1:0] module_func_en,
   output logic [NMOD-1:0] module_regs_en
);
   import psc_pkg::*;

   initial
   begin
      if (NMOD < 1 || NMOD > 8 || VREG_CYC < 1)
         $error("psc_top: unsupported parameters");
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic cpu_slowdown_enable_reg;
   logic roi_reg;
   logic [2:0] ratio_reg;
   logic regulator_standby_select_reg;
   logic [7:0] mdis_reg;
   logic [7:0] men_reg;
   logic [7:0] midl_reg;
   logic [2:0] new_oscillator_select_reg;
   logic lock_reg;
   logic [2:0] cosc_reg;
   logic switching_reg;
   psc_state_t state_reg;
   psc_state_t state_next;
   logic [15:0] wake_cnt_reg;
   logic [6:0] doze_cnt_reg;
   logic pend_reg;
   logic wdt_clr_reg;
   logic resume_reg;

   // ---------------------------------------------------------------
   // axi4-lite slave
   // ---------------------------------------------------------------
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [1:0] bresp_reg;
   logic bvalid_reg;
   logic rvalid_reg;

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == ADDR_CLOCK_DIVIDER_REGISTER) || (a == ADDR_RSTCTL) ||
         (a == ADDR_MODCTL) || (a == ADDR_STATUS) || (a == ADDR_OSCSEL);
   endfunction

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire [7:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
   wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
   wire have_aw = aw_held_reg || aw_take;
   wire have_w = w_held_reg || w_take;
   wire wr_fire = have_aw && have_w && !bvalid_reg;
   wire rd_fire = s_axi_arvalid && s_axi_arready;

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   wire wr_clock_divider_register = wr_fire && wr_addr == ADDR_CLOCK_DIVIDER_REGISTER;
   wire wr_rstctl = wr_fire && wr_addr == ADDR_RSTCTL;
   wire wr_modctl = wr_fire && wr_addr == ADDR_MODCTL;
   wire wr_oscsel = wr_fire && wr_addr == ADDR_OSCSEL;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end
      else
      begin
         if (aw_take)
            awaddr_reg <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         aw_held_reg <= wr_fire ? 1'b0 : have_aw;
         w_held_reg <= wr_fire ? 1'b0 : have_w;
         if (wr_fire)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   wire [31:0] rd_clock_divider_register = {16'h0000, roi_reg, ratio_reg, cpu_slowdown_enable_reg,
      11'h000};
   wire [31:0] rd_rstctl = {23'h000000, regulator_standby_select_reg, 8'h00};
   wire [31:0] rd_modctl = {8'h00, midl_reg, men_reg, mdis_reg};
   wire [31:0] rd_status = {24'h000000, switching_reg, pend_reg,
      cpu_clk_en, 3'h0, state_reg};
   wire [31:0] rd_oscsel = {24'h000000, cosc_reg[1:0], 1'b0, lock_reg,
      1'b0, new_oscillator_select_reg};
   wire [31:0] rd_mux =
      (s_axi_araddr == ADDR_CLOCK_DIVIDER_REGISTER) ? rd_clock_divider_register :
      (s_axi_araddr == ADDR_RSTCTL) ? rd_rstctl :
      (s_axi_araddr == ADDR_MODCTL) ? rd_modctl :
      (s_axi_araddr == ADDR_STATUS) ? rd_status :
      (s_axi_araddr == ADDR_OSCSEL) ? rd_oscsel : 32'h0000_0000;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp_reg <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   wire doze_exit = roi_reg && irq_pending;
   wire osc_unlocked = !lock_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cpu_slowdown_enable_reg <= 1'b0;
         roi_reg <= 1'b0;
         ratio_reg <= RATIO_RST;
         regulator_standby_select_reg <= 1'b0;
         mdis_reg <= 8'h00;
         men_reg <= MEN_RST;
         midl_reg <= 8'h00;
         new_oscillator_select_reg <= OSC_RST;
         lock_reg <= 1'b0;
         cosc_reg <= OSC_RST;
         switching_reg <= 1'b0;
      end
      else
      begin
         if (wr_clock_divider_register && wr_strb[1])
         begin
            cpu_slowdown_enable_reg <= wr_data[CPU_SLOWDOWN_ENABLE_BIT] && !doze_exit;
            roi_reg <= wr_data[ROI_BIT];
            ratio_reg <= wr_data[RATIO_LSB +: 3];
         end
         else if (doze_exit)
            cpu_slowdown_enable_reg <= 1'b0;
         if (wr_rstctl && wr_strb[1])
            regulator_standby_select_reg <= wr_data[REGULATOR_STANDBY_SELECT_BIT];
         if (wr_modctl)
         begin
            if (wr_strb[0])
               mdis_reg <= wr_data[MDIS_LSB +: 8];
            if (wr_strb[1])
               men_reg <= wr_data[MEN_LSB +: 8];
            if (wr_strb[2])
               midl_reg <= wr_data[MIDL_LSB +: 8];
         end
         if (wr_oscsel && wr_strb[0])
         begin
            lock_reg <= lock_reg || wr_data[LOCK_BIT];
            if (osc_unlocked)
            begin
               new_oscillator_select_reg <= wr_data[2:0];
               switching_reg <= 1'b1;
            end
         end
         else if (switching_reg && clock_switch_done)
         begin
            switching_reg <= 1'b0;
            cosc_reg <= new_oscillator_select_reg;
         end
      end
   end
   assign clock_switch_start = wr_oscsel && wr_strb[0] && osc_unlocked;
   assign active_osc = cosc_reg;

   // ---------------------------------------------------------------
   // sleep / idle sequencer
   // ---------------------------------------------------------------
   wire wake_evt = irq_pending || pend_reg || wdt_timeout;
   wire vreg_off = !regulator_standby_select_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PS_RUN:
            if (pwrsave_exec)
               state_next = (pwrsave_operand == OPER_SLEEP) ? PS_SLEEP :
                  PS_IDLE;
         PS_SLEEP:
            if (wake_evt)
               state_next = vreg_off ? PS_WAKE : PS_RUN;
         PS_IDLE:
            if (wake_evt)
               state_next = PS_RUN;
         PS_WAKE:
            if (wake_cnt_reg == 16'h0001)
               state_next = PS_RUN;
         default:
            state_next = PS_RUN;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= PS_RUN;
         wake_cnt_reg <= 16'h0000;
         pend_reg <= 1'b0;
         wdt_clr_reg <= 1'b0;
         resume_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == PS_RUN && pwrsave_exec && irq_pending)
            pend_reg <= 1'b1;
         else if (state_reg != PS_RUN && state_next == PS_RUN)
            pend_reg <= 1'b0;
         if (state_next == PS_WAKE && state_reg == PS_SLEEP)
            wake_cnt_reg <= 16'(VREG_CYC);
         else if (wake_cnt_reg != 16'h0000)
            wake_cnt_reg <= wake_cnt_reg - 16'h0001;
         wdt_clr_reg <= state_reg == PS_RUN && pwrsave_exec &&
            (wdt_enable || pwrsave_operand == OPER_IDLE);
         resume_reg <= state_reg != PS_RUN && state_next == PS_RUN;
      end
   end
   assign wdt_clear = wdt_clr_reg;
   assign cpu_resume = resume_reg;

   // ---------------------------------------------------------------
   // doze divider: enable pulse every 2**ratio cycles
   // ---------------------------------------------------------------
   wire [6:0] doze_max = 7'((8'h01 << ratio_reg) - 8'h01);
   wire doze_tick = !cpu_slowdown_enable_reg || doze_cnt_reg >= doze_max;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !cpu_slowdown_enable_reg)
         doze_cnt_reg <= 7'h00;
      else if (doze_tick)
         doze_cnt_reg <= 7'h00;
      else
         doze_cnt_reg <= doze_cnt_reg + 7'h01;
   end

   // ---------------------------------------------------------------
   // clock gating outputs
   // ---------------------------------------------------------------
   wire in_sleep = state_reg == PS_SLEEP || state_reg == PS_WAKE;
   wire in_idle = state_reg == PS_IDLE;
   assign cpu_clk_en = state_reg == PS_RUN && doze_tick;
   assign sys_clk_en = !in_sleep;
   assign osc_enable = !in_sleep;
   assign periph_clk_en = !in_sleep;
   assign fail_safe_clock_monitor_active = fail_safe_clock_monitor_enable && !in_sleep;
   assign low_power_rc_clock_enable = wdt_enable || (!in_sleep && fail_safe_clock_monitor_enable);
   assign vreg_standby = state_reg == PS_SLEEP && vreg_off;

   genvar gi;
   generate
      for (gi = 0; gi < NMOD; gi++)
      begin : g_mod
         assign module_clk_en[gi] = !mdis_reg[gi] && !in_sleep &&
            !(in_idle && midl_reg[gi]);
         assign module_regs_en[gi] = !mdis_reg[gi];
         assign module_func_en[gi] = men_reg[gi] && module_clk_en[gi];
      end
   endgenerate

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == PS_RUN && pwrsave_exec && !pwrsave_operand
      |=> in_sleep)
      else $error("sleep not entered");
   a_idle_entry: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == PS_RUN && pwrsave_exec && pwrsave_operand
      |=> in_idle && sys_clk_en && !cpu_clk_en)
      else $error("idle entry wrong");
   a_wake_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      in_idle && wdt_timeout |=> state_reg == PS_RUN && cpu_resume)
      else $error("idle wake missing");
   a_wdt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == PS_RUN && pwrsave_exec && wdt_enable |=> wdt_clear)
      else $error("watchdog not cleared");
   a_fail_safe_clock_monitor_off: assert property (@(posedge aclk) disable iff (!aresetn)
      in_sleep |-> !fail_safe_clock_monitor_active && !osc_enable)
      else $error("monitor active in sleep");
   a_pend_wake: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == PS_RUN && pwrsave_exec && irq_pending
      |=> state_reg != PS_RUN ##1 state_reg == PS_RUN ||
         state_reg == PS_WAKE)
      else $error("pending interrupt lost");
   a_doze_roi: assert property (@(posedge aclk) disable iff (!aresetn)
      roi_reg && irq_pending && !wr_clock_divider_register |=> !cpu_slowdown_enable_reg)
      else $error("return on interrupt failed");
   a_doze_full: assert property (@(posedge aclk) disable iff (!aresetn)
      cpu_slowdown_enable_reg && ratio_reg == 3'h1 && $stable(cpu_slowdown_enable_reg) &&
      $stable(ratio_reg) && cpu_clk_en && state_reg == PS_RUN
      |=> !cpu_clk_en)
      else $error("doze pulse too frequent");
   a_mod_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      mdis_reg[0] |-> !module_clk_en[0] && !module_regs_en[0])
      else $error("disabled module clocked");
endmodule

/* File: verif/power_saving_clock_gating_test.sv */
// self-checking bench for the power-saving clock control block
module power_saving_clock_gating_test;
   import psc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, pwrsave_exec, pwrsave_operand, irq_pending;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic wdt_timeout, wdt_enable, fail_safe_clock_monitor_enable, clock_switch_done;
   logic cpu_clk_en, sys_clk_en, periph_clk_en, osc_enable, low_power_rc_clock_enable;
   logic fail_safe_clock_monitor_active, wdt_clear, vreg_standby, cpu_resume;
   logic clock_switch_start;
   logic [2:0] active_osc;
   logic [7:0] module_clk_en, module_func_en, module_regs_en;
   int num_errors = 0;
   int checks = 0;
   int n, cnt, k, s0;
   always #25 aclk = ~aclk;
   psc_top #(.VREG_CYC(4)) DUT (.*);
   psc_core_model core (.*);
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got,
                        input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic timeout();
      num_errors++;
      $display("wrong value wait limit reached");
      final_report();
   endtask
   // ---------------------------------------------------------------
   // bus tasks: ready is looked at mid-cycle, before the taking edge
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
      logic ta, tw, tb;
      int i;
      tb = 1'b0;
      i = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!tb && i < 50)
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         i++;
      end
      if (!tb) timeout();
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tb;
      int i;
      tb = 1'b0;
      i = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!tb && i < 50)
      begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tb = s_axi_rvalid;
         v = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tb) s_axi_rready <= 1'b0;
         i++;
      end
      if (!tb) timeout();
   endtask
   task automatic wait_resume(input int lim);
      n = 0;
      while (cpu_resume !== 1'b1 && n < lim)
      begin
         @(negedge aclk);
         n++;
      end
      if (n == lim) timeout();
   endtask
   task automatic wait_sys();
      n = 0;
      while (sys_clk_en !== 1'b1 && n < 40)
      begin
         @(negedge aclk);
         n++;
      end
      if (n == 40) timeout();
   endtask
   task automatic count_cpu(input int len);
      cnt = 0;
      repeat (len)
      begin
         @(negedge aclk);
         cnt += cpu_clk_en;
         check("domains run", sys_clk_en & periph_clk_en, 1);
      end
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_CLOCK_DIVIDER_REGISTER);
      check("clock_divider_register reset", v, 32'h0);
      rd(ADDR_MODCTL);
      check("modctl reset", v, 32'h0000ff00);
      check("func reset", module_func_en, 8'hff);
      rd(8'h40);
      check("unmapped resp", resp, RESP_SLVERR);
      $display("test reset done");
      wr(ADDR_OSCSEL, 32'h3);
      for (n = 0; n < 30 && active_osc !== 3'h3; n++) @(negedge aclk);
      check("osc switched", active_osc, 3'h3);
      $display("test clock switch done");
      for (k = 0; k < 8; k++)
      begin
         wr(ADDR_CLOCK_DIVIDER_REGISTER, 32'h800 | (k << 12));
         count_cpu(256);
         check("doze pulses", cnt, 256 >> k);
      end
      wr(ADDR_CLOCK_DIVIDER_REGISTER, 32'h3800);
      core.wake(1'b0);
      core.drop();
      rd(ADDR_CLOCK_DIVIDER_REGISTER);
      check("no return", v, 32'h3800);
      wr(ADDR_CLOCK_DIVIDER_REGISTER, 32'hb800);
      core.wake(1'b0);
      core.drop();
      rd(ADDR_CLOCK_DIVIDER_REGISTER);
      check("return clears", v, 32'hb000);
      count_cpu(16);
      check("full speed", cnt, 16);
      wr(ADDR_CLOCK_DIVIDER_REGISTER, 32'h0);
      $display("test doze done");
      core.cfg(1'b0, 1'b1);
      core.power_save(OPER_IDLE, 1'b0);
      @(negedge aclk);
      check("idle cpu", cpu_clk_en, 0);
      check("idle sys", sys_clk_en & periph_clk_en, 1);
      check("idle wdt", wdt_clear, 1);
      check("idle rc", low_power_rc_clock_enable, 1);
      core.wake(1'b0);
      wait_resume(6);
      check("idle wake", n <= 3, 1);
      check("cpu back", cpu_clk_en, 1);
      core.drop();
      core.power_save(OPER_IDLE, 1'b1);
      @(negedge aclk);
      check("held irq entry", cpu_clk_en, 0);
      wait_resume(8);
      core.drop();
      $display("test idle done");
      wr(ADDR_MODCTL, 32'h0004fd01);
      check("md clock", module_clk_en[0] | module_regs_en[0], 0);
      check("en regs", module_regs_en[1] & module_clk_en[1], 1);
      check("en func", module_func_en[1], 0);
      core.power_save(OPER_IDLE, 1'b0);
      @(negedge aclk);
      check("stop idle", module_func_en[2] & module_clk_en[2], 0);
      check("keep idle", module_func_en[3], 1);
      core.wake(1'b1);
      wait_resume(6);
      check("idle wdt wake", n <= 3, 1);
      core.drop();
      wr(ADDR_MODCTL, 32'h0000ff00);
      // only the low lane may land: enable and stop-idle bytes stay
      wr(ADDR_MODCTL, 32'h00ff00ff, 4'h1);
      rd(ADDR_MODCTL);
      check("strobe lane", v, 32'h0000ffff);
      wr(ADDR_MODCTL, 32'h0000ff00);
      $display("test modules done");
      wr(ADDR_RSTCTL, 32'h100);
      core.cfg(1'b1, 1'b1);
      core.power_save(OPER_SLEEP, 1'b0);
      @(negedge aclk);
      check("sleep clk", sys_clk_en | osc_enable | periph_clk_en, 0);
      check("sleep mon", fail_safe_clock_monitor_active, 0);
      check("sleep rc", low_power_rc_clock_enable, 1);
      check("sleep wdt", wdt_clear, 1);
      check("reg on", vreg_standby, 0);
      core.wake(1'b1);
      wait_sys();
      check("fast wake", n < 4, 1);
      check("same osc", active_osc, 3'h3);
      wait_resume(8);
      wr(ADDR_RSTCTL, 32'h0);
      core.cfg(1'b0, 1'b0);
      core.power_save(OPER_SLEEP, 1'b0);
      @(negedge aclk);
      check("reg standby", vreg_standby, 1);
      core.wake(1'b0);
      wait_sys();
      check("reg delay", n >= 4, 1);
      wait_resume(8);
      core.drop();
      $display("test sleep done");
      wr(ADDR_OSCSEL, 32'h13);
      repeat (10) @(posedge aclk);
      s0 = core.starts;
      wr(ADDR_OSCSEL, 32'h15);
      repeat (10) @(posedge aclk);
      check("locked start", core.starts - s0, 0);
      check("locked osc", active_osc, 3'h3);
      $display("test lock done");
      final_report();
   end
endmodule

/* File: verif/psc_core_model.sv */
// behavioural model of the processor core and oscillator side
module psc_core_model
#(
   parameter int SWITCH_LAT = 6
)
(
   input wire logic aclk,
   input wire logic clock_switch_start,
   output logic pwrsave_exec,
   output logic pwrsave_operand,
   output logic irq_pending,
   output logic wdt_timeout,
   output logic wdt_enable,
   output logic fail_safe_clock_monitor_enable,
   output logic clock_switch_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int starts = 0;
   int lat = 0;
   initial
   begin
      pwrsave_exec = 1'b0;
      pwrsave_operand = 1'b0;
      irq_pending = 1'b0;
      wdt_timeout = 1'b0;
      wdt_enable = 1'b0;
      fail_safe_clock_monitor_enable = 1'b0;
      clock_switch_done = 1'b0;
   end
   // the oscillator answers slowly so the switch is seen in flight
   always @(posedge aclk)
   begin
      clock_switch_done <= (lat == 1);
      if (lat > 0)
         lat <= lat - 1;
      if (clock_switch_start)
      begin
         starts <= starts + 1;
         lat <= SWITCH_LAT;
      end
   end
   task automatic cfg(input logic w, input logic f);
      @(posedge aclk);
      wdt_enable <= w;
      fail_safe_clock_monitor_enable <= f;
   endtask
   // an interrupt may coincide with the instruction itself
   task automatic power_save(input logic op, input logic irq);
      @(posedge aclk);
      pwrsave_operand <= op;
      pwrsave_exec <= 1'b1;
      irq_pending <= irq;
      @(posedge aclk);
      pwrsave_exec <= 1'b0;
   endtask
   task automatic wake(input logic by_wdt);
      @(posedge aclk);
      irq_pending <= !by_wdt;
      wdt_timeout <= by_wdt;
      @(posedge aclk);
      wdt_timeout <= 1'b0;
   endtask
   task automatic drop();
      @(posedge aclk);
      irq_pending <= 1'b0;
   endtask
endmodule
